// File: cfdio_pkg.sv
// Constants, register map and types for the cell former digital I/O port
package cfdio_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_LINES  = 16;
  localparam int unsigned NUM_PAIRS  = 8;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned SYNC_DEPTH = 2;
  localparam int unsigned NUM_FUNCS  = 6;
  localparam int unsigned NUM_IRQ    = 5;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_MODE     = 8'h00;
  localparam logic [7:0] REG_POL      = 8'h04;
  localparam logic [7:0] REG_OUT      = 8'h08;
  localparam logic [7:0] REG_PIN_RAW  = 8'h0C;
  localparam logic [7:0] REG_PIN_LOG  = 8'h10;
  localparam logic [7:0] REG_FUNC     = 8'h14;
  localparam logic [7:0] REG_CTRL     = 8'h18;
  localparam logic [7:0] REG_STATUS   = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned MODE_W      = 2;
  localparam int unsigned FSEL_W      = 5;
  localparam int unsigned CTRL_CLR    = 0;
  localparam int unsigned CTRL_PF_EN  = 1;
  localparam int unsigned FN_FAULT_IN = 0;
  localparam int unsigned FN_FAULT_OUT = 1;
  localparam int unsigned FN_ILOCK    = 2;
  localparam int unsigned FN_TRIG     = 3;
  localparam int unsigned FN_PF_IN    = 4;
  localparam int unsigned FN_PF_OUT   = 5;
  localparam int unsigned IRQ_FAULT   = 0;
  localparam int unsigned IRQ_TRIG    = 1;
  localparam int unsigned IRQ_ILOCK   = 2;
  localparam int unsigned IRQ_PF      = 3;
  localparam int unsigned IRQ_SAVED   = 4;

  // ---------------------------------------------------------------
  // Line modes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_IN    = 2'h0;
  localparam logic [1:0]  MODE_OUT   = 2'h1;
  localparam logic [1:0]  MODE_BIDIR = 2'h2;
  localparam logic [1:0]  MODE_ISO   = 2'h3;
  localparam logic [31:0] RST_MODE   = 32'h0000_0000;
  localparam logic [15:0] RST_POL    = 16'h0000;
  localparam logic [15:0] RST_OUT    = 16'h0000;
  localparam logic [29:0] RST_FUNC   = 30'h0000_0000;
  localparam logic [4:0]  RST_IRQ    = 5'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic [3:0] line;
  } cfdio_fsel_t;

  typedef struct packed {
    logic start;
    logic run;
    logic pause;
    logic halt;
    logic save_req;
  } cfdio_seq_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_PAUSE,
    ST_FAULT,
    ST_SHUTDOWN,
    ST_SAVED
  } cfdio_state_t;

endpackage

// File: cfdio_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module cfdio_sync #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// File: cfdio_port.sv
// Sixteen-line digital I/O port with forming-sequence special functions
// Behaviour
// - Sixteen lines each take their own mode (input, output, in/out, isolated) and function.
// - Each line has a polarity bit choosing high-true or low-true.
// - General purpose lines pass values between registers and pins and never touch the sequence.
// - An in/out line written one is released, written zero is pulled low.
// - Reading an in/out line gives the level really present on the pin.
// - Isolated outputs are fixed even/odd pairs, eight at most; odd-even pairing is impossible.
// - An isolated pair obeys only the polarity bit of its even line.
// - A low-true pair closes when asserted; a high-true pair opens when asserted.
// - An asserted fault input halts the sequence and asserts the fault output.
// - The fault output stays asserted until the fault clear command removes it.
// - The interlock input pauses the sequence by level, without fault, and resumes on release.
// - An assertion of the trigger input starts the sequence.
// - When enabled, an asserted power fail input shuts down and saves sequence state.
// - The power fail output asserts once the shutdown state is fully saved.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module cfdio_port #(
  parameter int unsigned LINES = 16
) (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 sys_rst_in,
  // Register port
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [31:0]          reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [31:0]          reg_rdata_out,
  // Digital lines, open collector: enable high pulls low
  input  wire logic [LINES-1:0]     pin_in,
  output logic      [LINES-1:0]     pin_out,
  output logic      [LINES-1:0]     pin_oe_out,
  // Forming sequence control
  input  wire logic                 seq_saved_in,
  output cfdio_pkg::cfdio_seq_t     seq_out,
  // Interrupt
  output logic                      irq_out
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0]                mode_ff;
  logic [LINES-1:0]           pol_ff;
  logic [LINES-1:0]           out_ff;
  logic [29:0]                func_ff;
  logic                       pf_en_ff;
  logic [4:0]                 irq_stat_ff;
  logic [4:0]                 irq_mask_ff;
  logic                       fault_ff;
  logic                       pf_done_ff;
  logic                       trig_prev_ff;
  logic                       ilock_prev_ff;
  logic                       pf_prev_ff;
  cfdio_pkg::cfdio_state_t    state_ff;
  logic [LINES-1:0]           pin_sync;
  logic [LINES-1:0]           pin_log;
  logic [LINES-1:0]           nxt_pin_out;
  logic [LINES-1:0]           nxt_pin_oe;
  logic [31:0]                nxt_rdata;
  cfdio_pkg::cfdio_fsel_t     fsel [cfdio_pkg::NUM_FUNCS];
  logic                       fault_in_act;
  logic                       ilock_act;
  logic                       trig_act;
  logic                       pf_in_act;
  logic                       trig_rise;
  logic                       clr_cmd;
  logic [4:0]                 irq_evt;
  logic                       wr_irq;

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  cfdio_sync #(
    .WIDTH      (LINES)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (pin_in),
    .sync_out   (pin_sync)
  );

  assign pin_log = pin_sync ^ pol_ff;

  // ---------------------------------------------------------------
  // Special function selection
  // ---------------------------------------------------------------
  genvar f;
  generate
    for (f = 0; f < cfdio_pkg::NUM_FUNCS; f++) begin : g_fsel
      assign fsel[f] = func_ff[f*cfdio_pkg::FSEL_W +: cfdio_pkg::FSEL_W];
    end
  endgenerate

  // Only mapped lines reach the sequence logic
  assign fault_in_act = fsel[cfdio_pkg::FN_FAULT_IN].en
                        & pin_log[fsel[cfdio_pkg::FN_FAULT_IN].line];
  assign ilock_act    = fsel[cfdio_pkg::FN_ILOCK].en
                        & pin_log[fsel[cfdio_pkg::FN_ILOCK].line];
  assign trig_act     = fsel[cfdio_pkg::FN_TRIG].en
                        & pin_log[fsel[cfdio_pkg::FN_TRIG].line];
  assign pf_in_act    = fsel[cfdio_pkg::FN_PF_IN].en & pf_en_ff
                        & pin_log[fsel[cfdio_pkg::FN_PF_IN].line];
  assign trig_rise    = trig_act & ~trig_prev_ff;
  assign clr_cmd      = reg_wr_in && (reg_addr_in == cfdio_pkg::REG_CTRL)
                        && reg_wdata_in[cfdio_pkg::CTRL_CLR];

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < LINES; i++) begin : g_line
      localparam int unsigned EVEN = i & ~1;
      logic [1:0] md;
      logic [1:0] md_even;
      logic       val;
      logic       closed;
      assign md      = mode_ff[i*cfdio_pkg::MODE_W +: cfdio_pkg::MODE_W];
      assign md_even = mode_ff[EVEN*cfdio_pkg::MODE_W +: cfdio_pkg::MODE_W];
      // Special outputs override the software value on their line
      assign val = (fsel[cfdio_pkg::FN_FAULT_OUT].en
                    && fsel[cfdio_pkg::FN_FAULT_OUT].line == i) ? fault_ff :
                   (fsel[cfdio_pkg::FN_PF_OUT].en
                    && fsel[cfdio_pkg::FN_PF_OUT].line == i) ? pf_done_ff :
                   out_ff[i];
      // Closed when asserted for low-true, open when asserted for high-true
      assign closed = out_ff[EVEN] ~^ pol_ff[EVEN];
      always_comb begin
        nxt_pin_out[i] = 1'b0;
        if (md_even == cfdio_pkg::MODE_ISO) begin
          // Even line steers both pins of the pair
          nxt_pin_oe[i] = closed;
        end else if (md == cfdio_pkg::MODE_OUT || md == cfdio_pkg::MODE_BIDIR) begin
          // Level one releases the collector, zero pulls low
          nxt_pin_oe[i] = ~(val ^ pol_ff[i]);
        end else begin
          // Input, or odd line asking for iso without its even partner
          nxt_pin_oe[i] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pin_out    <= '0;
      pin_oe_out <= '0;
    end else begin
      pin_out    <= nxt_pin_out;
      pin_oe_out <= nxt_pin_oe;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mode_ff  <= cfdio_pkg::RST_MODE;
      pol_ff   <= cfdio_pkg::RST_POL;
      out_ff   <= cfdio_pkg::RST_OUT;
      func_ff  <= cfdio_pkg::RST_FUNC;
      pf_en_ff <= 1'b0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        cfdio_pkg::REG_MODE: begin
          mode_ff <= reg_wdata_in;
        end
        cfdio_pkg::REG_POL: begin
          pol_ff <= reg_wdata_in[LINES-1:0];
        end
        cfdio_pkg::REG_OUT: begin
          out_ff <= reg_wdata_in[LINES-1:0];
        end
        cfdio_pkg::REG_FUNC: begin
          func_ff <= reg_wdata_in[29:0];
        end
        cfdio_pkg::REG_CTRL: begin
          pf_en_ff <= reg_wdata_in[cfdio_pkg::CTRL_PF_EN];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Forming sequence control
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_ff <= cfdio_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        cfdio_pkg::ST_IDLE: begin
          if (fault_in_act) begin
            state_ff <= cfdio_pkg::ST_FAULT;
          end else if (pf_in_act) begin
            state_ff <= cfdio_pkg::ST_SHUTDOWN;
          end else if (trig_rise) begin
            state_ff <= cfdio_pkg::ST_RUN;
          end
        end
        cfdio_pkg::ST_RUN, cfdio_pkg::ST_PAUSE: begin
          if (fault_in_act) begin
            state_ff <= cfdio_pkg::ST_FAULT;
          end else if (pf_in_act) begin
            state_ff <= cfdio_pkg::ST_SHUTDOWN;
          end else begin
            state_ff <= ilock_act ? cfdio_pkg::ST_PAUSE : cfdio_pkg::ST_RUN;
          end
        end
        cfdio_pkg::ST_FAULT: begin
          // Stay halted while the fault persists and until cleared
          if (clr_cmd && !fault_in_act) begin
            state_ff <= cfdio_pkg::ST_IDLE;
          end
        end
        cfdio_pkg::ST_SHUTDOWN: begin
          if (fault_in_act) begin
            state_ff <= cfdio_pkg::ST_FAULT;
          end else if (seq_saved_in) begin
            state_ff <= cfdio_pkg::ST_SAVED;
          end
        end
        cfdio_pkg::ST_SAVED: begin
          // Restart only after power returns, by a fresh trigger
          if (!pf_in_act) begin
            state_ff <= cfdio_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= cfdio_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Fault output: set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      fault_ff <= 1'b0;
    end else if (fault_in_act) begin
      fault_ff <= 1'b1;
    end else if (clr_cmd) begin
      fault_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pf_done_ff <= 1'b0;
    end else begin
      pf_done_ff <= (state_ff == cfdio_pkg::ST_SHUTDOWN && seq_saved_in && !fault_in_act)
                    || (state_ff == cfdio_pkg::ST_SAVED && pf_in_act);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      seq_out       <= '0;
      trig_prev_ff  <= 1'b0;
      ilock_prev_ff <= 1'b0;
      pf_prev_ff    <= 1'b0;
    end else begin
      seq_out.start    <= (state_ff == cfdio_pkg::ST_IDLE) && trig_rise
                          && !fault_in_act && !pf_in_act;
      seq_out.run      <= (state_ff == cfdio_pkg::ST_RUN);
      seq_out.pause    <= (state_ff == cfdio_pkg::ST_PAUSE);
      seq_out.halt     <= (state_ff == cfdio_pkg::ST_FAULT);
      seq_out.save_req <= (state_ff == cfdio_pkg::ST_SHUTDOWN);
      trig_prev_ff     <= trig_act;
      ilock_prev_ff    <= ilock_act;
      pf_prev_ff       <= pf_in_act;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  assign irq_evt[cfdio_pkg::IRQ_FAULT] = fault_in_act & ~fault_ff;
  assign irq_evt[cfdio_pkg::IRQ_TRIG]  = trig_rise;
  assign irq_evt[cfdio_pkg::IRQ_ILOCK] = ilock_act & ~ilock_prev_ff;
  assign irq_evt[cfdio_pkg::IRQ_PF]    = pf_in_act & ~pf_prev_ff;
  assign irq_evt[cfdio_pkg::IRQ_SAVED] = (state_ff == cfdio_pkg::ST_SHUTDOWN)
                                         && seq_saved_in && !fault_in_act;
  assign wr_irq = reg_wr_in && (reg_addr_in == cfdio_pkg::REG_IRQ_STAT);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq_stat_ff <= cfdio_pkg::RST_IRQ;
      irq_mask_ff <= cfdio_pkg::RST_IRQ;
      irq_out     <= 1'b0;
    end else begin
      // Write one clears; a new event in the same cycle survives
      irq_stat_ff <= (irq_stat_ff & ~(wr_irq ? reg_wdata_in[4:0] : 5'h00)) | irq_evt;
      if (reg_wr_in && reg_addr_in == cfdio_pkg::REG_IRQ_MASK) begin
        irq_mask_ff <= reg_wdata_in[4:0];
      end
      irq_out <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr_in)
      cfdio_pkg::REG_MODE:     nxt_rdata = mode_ff;
      cfdio_pkg::REG_POL:      nxt_rdata[LINES-1:0] = pol_ff;
      cfdio_pkg::REG_OUT:      nxt_rdata[LINES-1:0] = out_ff;
      // Actual pin level, not the written value
      cfdio_pkg::REG_PIN_RAW:  nxt_rdata[LINES-1:0] = pin_sync;
      cfdio_pkg::REG_PIN_LOG:  nxt_rdata[LINES-1:0] = pin_log;
      cfdio_pkg::REG_FUNC:     nxt_rdata[29:0] = func_ff;
      cfdio_pkg::REG_CTRL:     nxt_rdata[cfdio_pkg::CTRL_PF_EN] = pf_en_ff;
      cfdio_pkg::REG_STATUS:   nxt_rdata[5:0] = {pf_done_ff, fault_ff, 1'b0, state_ff};
      cfdio_pkg::REG_IRQ_STAT: nxt_rdata[4:0] = irq_stat_ff;
      cfdio_pkg::REG_IRQ_MASK: nxt_rdata[4:0] = irq_mask_ff;
      default:                 nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? nxt_rdata : 32'h0000_0000;
    end
  end

endmodule

// File: cfdio_port_asserts.sv
// Concurrent checks on the digital I/O port outputs
`timescale 1ns/1ps
module cfdio_port_asserts #(
  parameter int unsigned LINES = 16
) (
  // Clock and reset
  input wire logic                  ref_clk_in,
  input wire logic                  sys_rst_in,
  // Register port
  input wire logic [7:0]            reg_addr_in,
  input wire logic [31:0]           reg_wdata_in,
  input wire logic                  reg_wr_in,
  input wire logic                  reg_rd_in,
  input wire logic [31:0]           reg_rdata_out,
  // Lines
  input wire logic [LINES-1:0]      pin_in,
  input wire logic [LINES-1:0]      pin_out,
  input wire logic [LINES-1:0]      pin_oe_out,
  // Sequence and interrupt
  input wire logic                  seq_saved_in,
  input wire cfdio_pkg::cfdio_seq_t seq_out,
  input wire logic                  irq_out
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic clr_wr;
  assign clr_wr = reg_wr_in && reg_addr_in == cfdio_pkg::REG_CTRL
                  && reg_wdata_in[cfdio_pkg::CTRL_CLR];

  AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside its cycle");
  AST_PIN_OUT_LOW: assert property (pin_out == '0)
    else $error("line drive value not low");
  AST_START_PULSE: assert property (seq_out.start |=> !seq_out.start)
    else $error("start longer than one cycle");
  AST_START_RUN: assert property (seq_out.start |-> ##[0:1] seq_out.run)
    else $error("start without run");
  AST_SEQ_EXCL: assert property ($onehot0({seq_out.run, seq_out.pause, seq_out.halt,
                                           seq_out.save_req}))
    else $error("sequence levels overlap");
  AST_HALT_HOLD: assert property ($fell(seq_out.halt) |->
                                  $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3))
    else $error("halt dropped without clear");
  AST_HALT_TO_IDLE: assert property ($fell(seq_out.halt) |->
                                     !seq_out.run && !seq_out.pause && !seq_out.save_req)
    else $error("halt left to a busy state");
  AST_PAUSE_FROM_RUN: assert property ($rose(seq_out.pause) |-> $past(seq_out.run))
    else $error("pause not from run");
  AST_RUN_CAUSE: assert property ($rose(seq_out.run) |->
                  seq_out.start || $past(seq_out.start) || $past(seq_out.pause))
    else $error("run without trigger or resume");
  AST_SAVE_DONE: assert property (seq_out.save_req && seq_saved_in |->
                                  ##[1:2] !seq_out.save_req)
    else $error("save request stuck after save");
  AST_SAVE_NOT_FAULT: assert property ($rose(seq_out.save_req) |-> !$past(seq_out.halt))
    else $error("shutdown entered from fault");
endmodule

bind cfdio_port cfdio_port_asserts #(.LINES(LINES)) chk_u (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .seq_saved_in(seq_saved_in), .seq_out(seq_out),
  .irq_out(irq_out));

// File: cfdio_far_model.sv
// Far side: pulled-up wires, outside switches and the state saver
`timescale 1ns/1ps
module cfdio_far_model (
  // Clock
  input  wire logic        ref_clk_in,
  // Lines
  input  wire logic [15:0] pin_oe_in,
  input  wire logic [15:0] ext_low_in,
  output logic      [15:0] pin_lvl_out,
  // Save handshake
  input  wire logic        save_req_in,
  input  wire logic [3:0]  save_dly_in,
  output logic             saved_out
);
  int unsigned cnt_ff = 0;
  // Pull-up wins unless the port or a switch sinks the wire
  assign pin_lvl_out = ~(pin_oe_in | ext_low_in);
  assign saved_out = save_req_in === 1'b1 && cnt_ff >= save_dly_in;
  // Save takes a chosen number of cycles, restarts on each request
  always_ff @(posedge ref_clk_in) begin
    if (save_req_in !== 1'b1) begin
      cnt_ff <= 0;
    end else if (cnt_ff < 15) begin
      cnt_ff <= cnt_ff + 1;
    end
  end
endmodule

// File: cfdio_port_tb_top.sv
// Self-checking bench for the digital I/O port
`timescale 1ns/1ps
module cfdio_port_tb_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                  ref_clk_in   = 1'b0;
  logic                  sys_rst_in   = 1'b1;
  logic [7:0]            reg_addr_in  = 8'h00;
  logic [31:0]           reg_wdata_in = 32'h0000_0000;
  logic                  reg_wr_in    = 1'b0;
  logic                  reg_rd_in    = 1'b0;
  logic [31:0]           reg_rdata_out;
  logic [15:0]           pin_in;
  logic [15:0]           pin_out;
  logic [15:0]           pin_oe_out;
  logic [15:0]           ext_low      = 16'h0000;
  logic                  seq_saved_in;
  cfdio_pkg::cfdio_seq_t seq_out;
  logic                  irq_out;
  logic [31:0]           exp_q[$];
  logic                  rd_d         = 1'b0;
  logic [31:0]           mode;
  logic [15:0]           pol;
  logic [15:0]           outv;
  int                    miscompares  = 0;
  int                    cmp_count    = 0;
  int                    cycles       = 0;
  int                    start_cnt    = 0;

  always #50 ref_clk_in = ~ref_clk_in;

  cfdio_port #(.LINES(16)) dut_u (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .seq_saved_in(seq_saved_in), .seq_out(seq_out),
    .irq_out(irq_out));

  cfdio_far_model far_u (
    .ref_clk_in(ref_clk_in), .pin_oe_in(pin_oe_out), .ext_low_in(ext_low),
    .pin_lvl_out(pin_in), .save_req_in(seq_out.save_req), .save_dly_in(4'h5),
    .saved_out(seq_saved_in));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // Strobe drops for a cycle so no signal is assigned twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    tick(1);
    reg_wr_in <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    tick(1);
    reg_rd_in <= 1'b0;
    tick(1);
  endtask

  task automatic wait_seq(input logic [4:0] want);
    for (int k = 0; k < 40 && seq_out !== want; k++) tick(1);
    check("seq_out", {27'h0, seq_out}, {27'h0, want});
  endtask

  task automatic pulse(input logic [15:0] m);
    ext_low <= m;
    tick(4);
    ext_low <= 16'h0000;
  endtask

  function automatic logic [15:0] exp_oe(input logic [31:0] m, input logic [15:0] p,
                                         input logic [15:0] o);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) begin
      case (m[2*i +: 2])
        cfdio_pkg::MODE_OUT, cfdio_pkg::MODE_BIDIR: r[i] = ~(o[i] ^ p[i]);
        default: r[i] = 1'b0;
      endcase
      // Isolated even line steers both pins of its pair
      if (m[2*(i & 14) +: 2] == cfdio_pkg::MODE_ISO) r[i] = ~(o[i & 14] ^ p[i & 14]);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Read monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    rd_d <= reg_rd_in;
    if (rd_d) check("reg_rdata", reg_rdata_out, exp_q.pop_front());
    if (seq_out.start === 1'b1) start_cnt <= start_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h5746));
    tick(8);
    sys_rst_in <= 1'b0;
    tick(1);
    for (logic [7:0] a = 8'h00; a <= 8'h24; a += 8'h04)
      if (a != cfdio_pkg::REG_PIN_RAW && a != cfdio_pkg::REG_PIN_LOG) rd(a, 32'h0);
    rd(cfdio_pkg::REG_PIN_RAW, 32'h0000_FFFF);
    wr(8'h28, 32'hFFFF_FFFF);
    rd(8'h28, 32'h0);
    $display("test reset done");
    for (int n = 0; n < 8; n++) begin
      mode = $urandom;
      pol = 16'($urandom);
      outv = 16'($urandom);
      ext_low <= 16'($urandom);
      wr(cfdio_pkg::REG_MODE, mode);
      wr(cfdio_pkg::REG_POL, {16'h0, pol});
      wr(cfdio_pkg::REG_OUT, {16'h0, outv});
      tick(4);
      check("pin_oe", pin_oe_out, exp_oe(mode, pol, outv));
      rd(cfdio_pkg::REG_PIN_RAW, {16'h0, ~(exp_oe(mode, pol, outv) | ext_low)});
      rd(cfdio_pkg::REG_PIN_LOG, {16'h0, ~(exp_oe(mode, pol, outv) | ext_low) ^ pol});
      check("seq_idle", {27'h0, seq_out}, 32'h0);
      check("irq", irq_out, 1'b0);
    end
    $display("test lines done");
    ext_low <= 16'h0000;
    wr(cfdio_pkg::REG_MODE, 32'h0000_4040);
    wr(cfdio_pkg::REG_POL, 32'h0000_0074);
    wr(cfdio_pkg::REG_OUT, 32'h0);
    wr(cfdio_pkg::REG_FUNC, 32'h2F6A_D272);
    wr(cfdio_pkg::REG_IRQ_MASK, 32'h0000_001B);
    tick(4);
    check("flag_lines", pin_oe_out[7:0], 8'h88);
    pulse(16'h0020);
    wait_seq(5'h08);
    check("starts", start_cnt, 1);
    check("irq", irq_out, 1'b1);
    rd(cfdio_pkg::REG_IRQ_STAT, 32'h2);
    wr(cfdio_pkg::REG_IRQ_STAT, 32'h2);
    tick(2);
    check("irq", irq_out, 1'b0);
    ext_low <= 16'h0010;
    wait_seq(5'h04);
    tick(3);
    check("fault_line", pin_oe_out[3], 1'b1);
    check("irq_mask", irq_out, 1'b0);
    rd(cfdio_pkg::REG_IRQ_STAT, 32'h4);
    ext_low <= 16'h0000;
    wait_seq(5'h08);
    $display("test trigger interlock done");
    ext_low <= 16'h0004;
    wait_seq(5'h02);
    tick(1);
    check("fault_line", pin_oe_out[3], 1'b0);
    rd(cfdio_pkg::REG_STATUS, 32'h13);
    wr(cfdio_pkg::REG_CTRL, 32'h1);
    tick(3);
    wait_seq(5'h02);
    ext_low <= 16'h0000;
    tick(6);
    wait_seq(5'h02);
    check("fault_line", pin_oe_out[3], 1'b0);
    wr(cfdio_pkg::REG_CTRL, 32'h1);
    wait_seq(5'h00);
    tick(1);
    check("fault_line", pin_oe_out[3], 1'b1);
    rd(cfdio_pkg::REG_STATUS, 32'h0);
    wr(cfdio_pkg::REG_IRQ_STAT, 32'h1F);
    $display("test fault done");
    wr(cfdio_pkg::REG_CTRL, 32'h2);
    pulse(16'h0020);
    wait_seq(5'h08);
    ext_low <= 16'h0040;
    wait_seq(5'h01);
    check("pf_line", pin_oe_out[7], 1'b1);
    for (int k = 0; k < 40 && pin_oe_out[7] !== 1'b0; k++) tick(1);
    check("pf_line", pin_oe_out[7], 1'b0);
    rd(cfdio_pkg::REG_STATUS, 32'h25);
    rd(cfdio_pkg::REG_IRQ_STAT, 32'h1A);
    ext_low <= 16'h0000;
    tick(6);
    rd(cfdio_pkg::REG_STATUS, 32'h0);
    check("pf_line", pin_oe_out[7], 1'b1);
    $display("test power fail done");
    sys_rst_in <= 1'b1;
    tick(2);
    sys_rst_in <= 1'b0;
    tick(1);
    rd(cfdio_pkg::REG_MODE, 32'h0);
    check("pin_oe", pin_oe_out, 16'h0000);
    $display("test second reset done");
    results();
  end
endmodule
